/* File: logic/serial_host_regs.svh */
// Purpose: Named offsets, field positions, reset values and timing counts.
// Assumes: System clock of 25 MHz, a period of 40 ns.
// Notes:   Times are kept in ns; cycle counts derive from them.
`ifndef SERIAL_HOST_REGS_SVH
`define SERIAL_HOST_REGS_SVH

`define CLK_PERIOD_NS      40
`define SCLK_MIN_PERIOD_NS 200
`define CS_GAP_MIN_NS      150
`define CS_QUIET_MIN_NS    5

// Least times round up to whole cycles.
`define SCLK_HALF_CYC ((`SCLK_MIN_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_GAP_CYC    ((`CS_GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_QUIET_CYC  ((`CS_QUIET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define DIV_W          8
`define ADDR_W         6
`define LEN_W          6
`define RW_BIT         7
`define MULTI_BIT      6
`define BIT_LAST       3'h7
`define BIT_FIRST      3'h0
`define LEN_ONE        6'h01
`define LEN_ZERO       6'h00
`define DIV_ZERO       8'h00
`define DIV_ONE        8'h01
`define BYTE_ZERO      8'h00

// Device register holding the wire-mode bit.
`define OUTPUT_FORMAT_CTRL_OFFSET 6'h31

`endif

/* File: logic/serial_host_pkg.sv */
// Purpose: Types shared by the serial host controller.
// Assumes: serial_host_regs.svh supplies the widths.
// Notes:   All controller state is one packed struct.
`include "serial_host_regs.svh"

package serial_host_pkg;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_setup = 3'h1,
    st_low   = 3'h3,
    st_high  = 3'h2,
    st_hold  = 3'h6,
    st_gap   = 3'h7
  } state_type;

  typedef struct packed {
    state_type          st;
    logic [`DIV_W-1:0]  div;
    logic [2:0]         bits;
    logic [`LEN_W-1:0]  left;
    logic               hdr;
    logic [7:0]         sh;
    logic               rd;
    logic               tw;
    logic               cs_n;
    logic               sclk;
    logic               mosi;
    logic               oe;
    logic [7:0]         rdat;
    logic               rvalid;
    logic               wtake;
    logic               done;
    logic               miso_m;
    logic               miso_s;
    logic               sdio_m;
    logic               sdio_s;
  } ctrl_type;

endpackage

/* File: logic/serial_host.sv */
// Purpose: SPI master that reaches the sensor register map over its pins.
// Assumes: One 25 MHz clock; the serial clock is divided from it.
// Notes:   Serial clock idles high; mode 3 timing; 3- or 4-wire data.
`timescale 1ns/10ps
`include "serial_host_regs.svh"

// Summary of operation
// - Chip select is always actively driven, never left floating.
// - This master owns and drives chip select for every transfer.
// - Data returned by the device during writes is ignored.
// - Serial clock never exceeds 5 MHz; period at least 200 ns.
// - Clock polarity 1 and clock phase 1 on both sides.
// - Chip select stays high from reset before any timing is used.
// - Chip select falls at transfer start and rises at transfer end.
// - Master supplies the serial clock and holds it high when idle.
// - Outgoing bits change on falling edges; incoming sampled on rising.
// - Multi-byte flag follows the read/write bit to access many registers.
// - Non-consecutive registers need a new transfer with a new address.
// - Chip select stays high at least 150 ns between transfers.
// - Bus rate should suit data rate: 2 MHz for 3200 and 1600 Hz; this host always runs the serial clock at a 240 ns period.
// - Chip select, clock and mosi are actively driven by the host; sdio only while the host sends in 3-wire mode.
module serial_host #(
  parameter logic [`DIV_W-1:0] HALF_CYCLES = `DIV_W'(`SCLK_HALF_CYC),
  parameter logic [`DIV_W-1:0] GAP_CYCLES  = `DIV_W'(`CS_GAP_CYC),
  parameter logic [`DIV_W-1:0] QUIET_CYCLES = `DIV_W'(`CS_QUIET_CYC)
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic               cmd_read,
  input  wire logic [`ADDR_W-1:0] cmd_addr,
  input  wire logic [`LEN_W-1:0]  cmd_len,
  input  wire logic               three_wire,
  input  wire logic [7:0]         wr_data,
  output logic                    wr_take,
  output logic [7:0]              rd_data,
  output logic                    rd_valid,
  output logic                    done,
  output logic                    busy,
  output logic                    cs_n,
  output logic                    sclk,
  output logic                    mosi,
  input  wire logic               miso,
  input  wire logic               sdio_in,
  output logic                    sdio_out,
  output logic                    sdio_oe
);
  import serial_host_pkg::*;

  localparam ctrl_type RESET_STATE = '{
    st:     st_idle,
    div:    `DIV_ZERO,
    bits:   `BIT_FIRST,
    left:   `LEN_ZERO,
    hdr:    1'b0,
    sh:     `BYTE_ZERO,
    rd:     1'b0,
    tw:     1'b0,
    cs_n:   1'b1,
    sclk:   1'b1,
    mosi:   1'b0,
    oe:     1'b0,
    rdat:   `BYTE_ZERO,
    rvalid: 1'b0,
    wtake:  1'b0,
    done:   1'b0,
    miso_m: 1'b0,
    miso_s: 1'b0,
    sdio_m: 1'b0,
    sdio_s: 1'b0
  };

  ctrl_type q;
  ctrl_type n;

  logic             din;
  logic             last_byte;
  logic [`LEN_W-1:0] len_eff;
  logic [7:0]       rx_byte;

  // The received bit comes from whichever data line the wire mode uses.
  assign din       = q.tw ? q.sdio_s : q.miso_s;
  assign last_byte = !q.hdr && (q.left == `LEN_ONE);
  assign len_eff   = (cmd_len == `LEN_ZERO) ? `LEN_ONE : cmd_len;
  assign rx_byte   = {q.sh[6:0], din};

  always_comb begin
    n        = q;
    n.rvalid = 1'b0;
    n.wtake  = 1'b0;
    n.done   = 1'b0;
    // Pins from the device pass two flip-flops before use.
    n.miso_m = miso;
    n.miso_s = q.miso_m;
    n.sdio_m = sdio_in;
    n.sdio_s = q.sdio_m;

    case (q.st)
      st_idle: begin
        n.cs_n = 1'b1;
        n.sclk = 1'b1;
        n.oe   = 1'b0;
        if (cmd_valid) begin
          n.cs_n = 1'b0;
          n.sh   = {cmd_read, (len_eff > `LEN_ONE), cmd_addr};
          n.sh[`MULTI_BIT] = (len_eff > `LEN_ONE);
          n.left = len_eff;
          n.hdr  = 1'b1;
          n.rd   = cmd_read;
          n.tw   = three_wire;
          n.oe   = three_wire;
          n.bits = `BIT_FIRST;
          n.div  = HALF_CYCLES - `DIV_ONE;
          n.st   = st_setup;
        end
      end

      st_setup: begin
        if (q.div == `DIV_ZERO) begin
          // First falling edge puts out the first bit.
          n.sclk = 1'b0;
          n.mosi = q.sh[`RW_BIT];
          n.div  = HALF_CYCLES - `DIV_ONE;
          n.st   = st_low;
        end else begin
          n.div = q.div - `DIV_ONE;
        end
      end

      st_low: begin
        if (q.div == `DIV_ZERO) begin
          n.sclk = 1'b1;
          n.sh   = rx_byte;
          n.bits = q.bits + 3'h1;
          n.div  = HALF_CYCLES - `DIV_ONE;
          n.st   = st_high;
          if (q.bits == `BIT_LAST) begin
            n.hdr = 1'b0;
            if (!q.hdr) begin
              n.left = q.left - `LEN_ONE;
            end
            if (!q.hdr && q.rd) begin
              n.rdat   = rx_byte;
              n.rvalid = 1'b1;
            end
            // Bytes coming back during a write are simply dropped.
            if (!q.rd && !last_byte) begin
              n.sh    = wr_data;
              n.wtake = 1'b1;
            end
            if (last_byte) begin
              n.div = QUIET_CYCLES - `DIV_ONE;
              n.st  = st_hold;
            end
          end
        end else begin
          n.div = q.div - `DIV_ONE;
        end
      end

      st_high: begin
        if (q.div == `DIV_ZERO) begin
          n.sclk = 1'b0;
          // During read data the host sends zeros and, in 3-wire mode,
          // releases the shared line so the device may drive it.
          n.mosi = (q.rd && !q.hdr) ? 1'b0 : q.sh[`RW_BIT];
          n.oe   = q.tw && !(q.rd && !q.hdr);
          n.div  = HALF_CYCLES - `DIV_ONE;
          n.st   = st_low;
        end else begin
          n.div = q.div - `DIV_ONE;
        end
      end

      st_hold: begin
        if (q.div == `DIV_ZERO) begin
          // Clock is already high; end the frame and release the line.
          n.cs_n = 1'b1;
          n.oe   = 1'b0;
          n.done = 1'b1;
          n.div  = GAP_CYCLES - `DIV_ONE;
          n.st   = st_gap;
        end else begin
          n.div = q.div - `DIV_ONE;
        end
      end

      st_gap: begin
        // Data goes back to its idle level only after chip select is up.
        n.mosi = 1'b0;
        if (q.div == `DIV_ZERO) begin
          n.st = st_idle;
        end else begin
          n.div = q.div - `DIV_ONE;
        end
      end

      default: begin
        n = RESET_STATE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign cmd_ready = (q.st == st_idle);
  assign wr_take   = q.wtake;
  assign rd_data   = q.rdat;
  assign rd_valid  = q.rvalid;
  assign done      = q.done;
  assign busy      = (q.st != st_idle);
  assign cs_n      = q.cs_n;
  assign sclk      = q.sclk;
  assign mosi      = q.mosi;
  assign sdio_out  = q.mosi;
  assign sdio_oe   = q.oe;

endmodule // serial_host

/* File: verif/serial_host_checker.sv */
// Purpose: Pin checks for the serial host.
// Assumes: Three clock cycles per serial half period.
// Notes:   Bound into serial_host.
`timescale 1ns/10ps
module serial_host_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_sclk_idle: assert property (cs_n |-> sclk)
    else $error("sclk low idle");
  chk_cs_gap: assert property ($rose(cs_n) |=> cs_n [*3])
    else $error("short gap");
  chk_done_edge: assert property (done |-> $rose(cs_n))
    else $error("stray done");
  chk_take_frame: assert property (cmd_valid && cmd_ready |=> !cs_n)
    else $error("no frame");
  chk_low_time: assert property ($fell(sclk) |=> !sclk [*2] ##1 sclk)
    else $error("bad low time");
  chk_data_hold: assert property ($rose(sclk) && !cs_n |=> $stable(mosi))
    else $error("data moved");
  chk_oe_frame: assert property (cs_n && $past(cs_n) |-> !sdio_oe)
    else $error("line driven idle");
  chk_sdio_value: assert property (sdio_oe |-> sdio_out == mosi)
    else $error("bad line value");
  cover property (done);
  cover property ($rose(sdio_oe));
  cover property ($fell(sdio_oe) && !cs_n);
endmodule // serial_host_checker
bind serial_host serial_host_checker serial_host_checker_inst (.clock, .rst,
  .cmd_valid, .cmd_ready, .done, .cs_n, .sclk, .mosi, .sdio_out, .sdio_oe);

/* File: verif/sensor_model.sv */
// Purpose: Behavioural sensor serial port, 64 byte register map.
// Assumes: Registers read zero after power up.
// Notes:   Wire-mode bit position is a plain default.
`timescale 1ns/10ps
module sensor_model #(parameter int WIRE_BIT = 6) (
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic sdio,
  output logic      miso,
  output logic      dev_oe,
  output logic      dev_bit
);
  logic [7:0] mem [64] = '{default: 8'h00};
  logic [7:0] sh, ob = 8'h00;
  logic [5:0] ad;
  logic       rd, mb, tw, drv = 1'b0, last = 1'b0;
  int         n = 0;
  assign tw = mem[6'h31][WIRE_BIT];
  assign dev_oe = drv & tw;
  assign dev_bit = ob[7];
  assign miso = (drv & ~tw) ? ob[7] : ~last;
  always @(posedge cs_n) {n, drv} = '0;
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], tw ? sdio : mosi};
    n++;
    if (n == 8) {rd, mb, ad} = sh;
    else if (n % 8 == 0) begin
      if (!rd) mem[ad] = sh;
      if (mb) ad++;
    end
  end
  always @(negedge sclk) if (!cs_n && rd && n >= 8) begin
    last = ob[7];
    ob = (n % 8 == 0) ? mem[ad] : {ob[6:0], 1'b0};
    drv = 1'b1;
  end
endmodule // sensor_model

/* File: verif/serial_host_test.sv */
// Purpose: Self-checking bench for serial_host and a sensor model.
// Assumes: Data bytes of a transfer count up from a base value.
// Notes:   Register contents carry over between tests.
`timescale 1ns/10ps
module serial_host_test;
  logic       clock, rst, cmd_valid, cmd_ready, cmd_read, three_wire, wr_take;
  logic       rd_valid, done, cs_n, sclk, mosi, miso, sdio, sdio_out;
  logic       sdio_oe, dev_oe, dev_bit, wl;
  logic [5:0] cmd_addr, cmd_len;
  logic [7:0] wr_data, rd_data;
  int         num_errors, checks, cyc;
  assign sdio = sdio_oe ? sdio_out : dev_oe ? dev_bit : ~wl;
  serial_host serial_host_inst (.clock, .rst, .cmd_valid, .cmd_ready,
    .cmd_read, .cmd_addr, .cmd_len, .three_wire, .wr_data, .wr_take, .rd_data,
    .rd_valid, .done, .busy(), .cs_n, .sclk, .mosi, .miso, .sdio_in(sdio),
    .sdio_out, .sdio_oe);
  sensor_model sensor_model_inst (.cs_n, .sclk, .mosi, .sdio, .miso, .dev_oe,
    .dev_bit);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (sdio_oe || dev_oe) wl <= sdio;
    if (++cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic r, t, input logic [5:0] a, n,
    input logic [7:0] b);
    int k = 0, w;
    @(posedge clock);
    #1 {cmd_valid, cmd_read, three_wire} = {1'b1, r, t};
    {cmd_addr, cmd_len, wr_data} = {a, n, b};
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    for (w = 0; w < 3000 && done !== 1'b1; w++) begin
      @(posedge clock);
      #1;
      if (wr_take === 1'b1) wr_data = b + 8'(++k);
      if (rd_valid === 1'b1) check(rd_data, b + 8'(k++));
    end
    check(8'(k), {2'h0, n});
    for (w = 0; w < 50 && cmd_ready !== 1'b1; w++) @(negedge clock);
    $display("Test at %h done", a);
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {clock, rst, cmd_valid, cmd_read, three_wire, wl} = 6'h10;
    {cmd_addr, cmd_len, wr_data, num_errors, checks, cyc} = '0;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    run(1'b0, 1'b0, 6'h10, 6'h04, 8'ha0);
    run(1'b1, 1'b0, 6'h10, 6'h04, 8'ha0);
    run(1'b0, 1'b0, 6'h31, 6'h01, 8'h40);
    run(1'b0, 1'b1, 6'h20, 6'h03, 8'h71);
    run(1'b1, 1'b1, 6'h20, 6'h03, 8'h71);
    run(1'b1, 1'b1, 6'h31, 6'h01, 8'h40);
    give_verdict();
  end
endmodule // serial_host_test
